// >>> design/sapc_pkg.sv
// package: offsets, field layouts and reset values of the split and power regs
package sapc_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] SAPC_OFF_UP_SPLIT = 8'h88;
  localparam logic [7:0] SAPC_OFF_DN_SPLIT = 8'h8c;
  localparam logic [7:0] SAPC_OFF_PM_CAP = 8'h90;
  localparam logic [7:0] SAPC_OFF_SPLIT_REQ = 8'ha0;
  localparam logic [7:0] SAPC_OFF_SPLIT_STAT = 8'ha4;
  // ****************************************
  // field positions and values
  // ****************************************
  localparam int SAPC_LIMIT_LSB = 16;
  localparam logic [15:0] SAPC_UP_CAP = 16'h0010;
  localparam logic [15:0] SAPC_DN_CAP = 16'h0010;
  localparam logic [15:0] SAPC_UP_LIMIT_RST = 16'h0010;
  localparam logic [15:0] SAPC_LIMIT_ALL = 16'hffff;
  localparam logic [7:0] SAPC_PM_ID = 8'h01;
  localparam logic [7:0] SAPC_NEXT_PTR = 8'ha8;
  localparam logic [2:0] SAPC_PM_VERSION = 3'h2;
  localparam logic [0:0] SAPC_PME_CLOCK = 1'h0;
  localparam logic [0:0] SAPC_PM_RSVD20 = 1'h0;
  localparam logic [0:0] SAPC_DSI = 1'h0;
  localparam logic [2:0] SAPC_AUX_CURRENT = 3'h1;
  localparam logic [0:0] SAPC_D1_SUPPORT = 1'h0;
  localparam logic [0:0] SAPC_D2_SUPPORT = 1'h0;
  localparam logic [4:0] SAPC_PME_SUPPORT = 5'h19;
  localparam logic [31:0] SAPC_UNMAPPED_RD = 32'h0000_0000;
endpackage

// >>> design/sapc_split_gate.sv
// split request gate for one direction: forward or hold by limit
`timescale 1ns/1ns
module sapc_split_gate
  import sapc_pkg::*;
(
  input wire logic [15:0] limit,
  input wire logic [15:0] outstanding,
  input wire logic [15:0] reqSize,
  input wire logic reqValid,
  output logic forward,
  output logic held
);
  logic [16:0] total;
  logic fits;
  logic unlimited;
  assign total = {1'b0, outstanding} + {1'b0, reqSize};
  assign unlimited = limit == SAPC_LIMIT_ALL;
  assign fits = total <= {1'b0, limit};
  assign forward = reqValid && (unlimited || fits);
  assign held = reqValid && !(unlimited || fits);
endmodule

// >>> design/sapc_regs.sv
// split transaction and power capability register group on apb
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module sapc_regs
  import sapc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic upReqValid,
  input wire logic [15:0] upReqSize,
  input wire logic [15:0] upOutstanding,
  input wire logic dnReqValid,
  input wire logic [15:0] dnReqSize,
  input wire logic [15:0] dnOutstanding,
  output logic upForward,
  output logic dnForward,
  output logic upHeld,
  output logic dnHeld
);
  // ****************************************
  // state
  // ****************************************
  logic [15:0] upLimit_r;
  logic [15:0] dnLimit_r;
  logic [15:0] upLimit_nxt;
  logic [15:0] dnLimit_nxt;
  logic upDelayed_r;
  logic dnDelayed_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic upForward_r;
  logic dnForward_r;
  logic upHeld_r;
  logic dnHeld_r;

  // ****************************************
  // apb decode
  // ****************************************
  // answer one cycle after the first access cycle; pready is a registered pulse
  // pready_r in the decode keeps one transfer from being taken twice
  logic access;
  logic wrAcc;
  logic selUp;
  logic selDn;
  logic selPm;
  logic selStat;
  logic selReq;
  logic mapped;
  logic clrUp;
  logic clrDn;
  assign access = psel && penable && !pready_r;
  assign wrAcc = access && pwrite;
  assign selUp = paddr == SAPC_OFF_UP_SPLIT;
  assign selDn = paddr == SAPC_OFF_DN_SPLIT;
  assign selPm = paddr == SAPC_OFF_PM_CAP;
  assign selStat = paddr == SAPC_OFF_SPLIT_STAT;
  assign selReq = paddr == SAPC_OFF_SPLIT_REQ;
  assign mapped = selUp || selDn || selPm || selStat || selReq;

  // ****************************************
  // limit writes, byte lanes honoured
  // ****************************************
  // only bits 31:16 take write data; capability halves stay constant
  // a limit below the capability is legal: software may throttle splits
  assign upLimit_nxt = {pstrb[3] ? pwdata[31:24] : upLimit_r[15:8],
                        pstrb[2] ? pwdata[23:16] : upLimit_r[7:0]};
  assign dnLimit_nxt = {pstrb[3] ? pwdata[31:24] : dnLimit_r[15:8],
                        pstrb[2] ? pwdata[23:16] : dnLimit_r[7:0]};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      upLimit_r <= SAPC_UP_LIMIT_RST;
      dnLimit_r <= SAPC_DN_CAP;
    end else begin
      if (wrAcc && selUp) begin
        upLimit_r <= upLimit_nxt;
      end
      if (wrAcc && selDn) begin
        dnLimit_r <= dnLimit_nxt;
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] upWord;
  logic [31:0] dnWord;
  logic [31:0] pmWord;
  logic [31:0] statWord;
  logic [31:0] reqWord;
  logic [31:0] rdMux;
  assign upWord = {upLimit_r, SAPC_UP_CAP};
  assign dnWord = {dnLimit_r, SAPC_DN_CAP};
  assign pmWord = {SAPC_PME_SUPPORT,
                   SAPC_D2_SUPPORT, SAPC_D1_SUPPORT,
                   SAPC_AUX_CURRENT,
                   SAPC_DSI,
                   SAPC_PM_RSVD20,
                   SAPC_PME_CLOCK,
                   SAPC_PM_VERSION,
                   SAPC_NEXT_PTR,
                   SAPC_PM_ID};
  assign statWord = {30'h0, dnDelayed_r, upDelayed_r};
  assign reqWord = {28'h0, dnHeld_r, upHeld_r, dnForward_r, upForward_r};
  assign rdMux = selUp ? upWord :
                 selDn ? dnWord :
                 selPm ? pmWord :
                 selStat ? statWord :
                 selReq ? reqWord : SAPC_UNMAPPED_RD;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access;
      pslverr_r <= access && !mapped;
      prdata_r <= (access && !pwrite) ? rdMux : 32'h0;
    end
  end

  // ****************************************
  // split request gating
  // ****************************************
  // results are registered, so they trail the request by one cycle
  // limitation: a held request is not retried here; the requester repeats it
  logic upFwdC;
  logic dnFwdC;
  logic upHeldC;
  logic dnHeldC;
  sapc_split_gate upGate (
    .limit(upLimit_r),
    .outstanding(upOutstanding),
    .reqSize(upReqSize),
    .reqValid(upReqValid),
    .forward(upFwdC),
    .held(upHeldC)
  );
  sapc_split_gate dnGate (
    .limit(dnLimit_r),
    .outstanding(dnOutstanding),
    .reqSize(dnReqSize),
    .reqValid(dnReqValid),
    .forward(dnFwdC),
    .held(dnHeldC)
  );

  // sticky delayed flags, write one to clear; a new hold wins over clear
  // the flags gather holds between reads, so a short burst is not missed
  assign clrUp = wrAcc && selStat && pstrb[0] && pwdata[0];
  assign clrDn = wrAcc && selStat && pstrb[0] && pwdata[1];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      upDelayed_r <= 1'b0;
      dnDelayed_r <= 1'b0;
      upForward_r <= 1'b0;
      dnForward_r <= 1'b0;
      upHeld_r <= 1'b0;
      dnHeld_r <= 1'b0;
    end else begin
      upDelayed_r <= upHeldC || (upDelayed_r && !clrUp);
      dnDelayed_r <= dnHeldC || (dnDelayed_r && !clrDn);
      upForward_r <= upFwdC;
      dnForward_r <= dnFwdC;
      upHeld_r <= upHeldC;
      dnHeld_r <= dnHeldC;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign upForward = upForward_r;
  assign dnForward = dnForward_r;
  assign upHeld = upHeld_r;
  assign dnHeld = dnHeld_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  pm_word_a: assert property (access && !pwrite && selPm |=>
    prdata == 32'hc842_a801) else $error("power capability word wrong");
  up_cap_a: assert property (access && !pwrite && selUp |=>
    prdata[15:0] == 16'h0010) else $error("upstream capability wrong");
  dn_cap_a: assert property (access && !pwrite && selDn |=>
    prdata[15:0] == 16'h0010) else $error("downstream capability wrong");
  up_store_a: assert property (
    wrAcc && selUp && pstrb[3:2] == 2'h3 |=>
    upLimit_r == $past(pwdata[31:16])) else $error("upstream limit lost");
  dn_store_a: assert property (
    wrAcc && selDn && pstrb[3:2] == 2'h3 |=>
    dnLimit_r == $past(pwdata[31:16])) else $error("downstream limit lost");
  up_hold_a: assert property (
    upReqValid && upLimit_r != 16'hffff &&
    {1'b0, upOutstanding} + {1'b0, upReqSize} > {1'b0, upLimit_r} |=>
    upHeld && upDelayed_r && !upForward) else $error("oversize not held");
  all_fwd_a: assert property (dnReqValid && dnLimit_r == 16'hffff |=>
    dnForward && !dnHeld) else $error("unlimited not forwarded");
  delay_sticky_a: assert property (dnDelayed_r && !clrDn |=>
    dnDelayed_r) else $error("delayed flag dropped");
  ready_pulse_a: assert property (access |=> pready ##1 !pready)
    else $error("pready not a single pulse");
  reset_lim_a: assert property ($rose(reset_n) |->
    upLimit_r == 16'h0010 && dnLimit_r == 16'h0010)
    else $error("limit reset wrong");

  // ****************************************
  // gate and bus answers
  // ****************************************
  // the sum is taken at 17 bits, so no wrap can hide an oversize request
  dn_hold_a: assert property (
    dnReqValid && dnLimit_r != 16'hffff &&
    {1'b0, dnOutstanding} + {1'b0, dnReqSize} > {1'b0, dnLimit_r} |=>
    dnHeld && dnDelayed_r && !dnForward) else $error("oversize not held");
  // equal to the limit still fits: the limit is inclusive
  up_fit_a: assert property (
    upReqValid &&
    {1'b0, upOutstanding} + {1'b0, upReqSize} <= {1'b0, upLimit_r} |=>
    upForward && !upHeld) else $error("fitting request held");
  dn_fit_a: assert property (
    dnReqValid &&
    {1'b0, dnOutstanding} + {1'b0, dnReqSize} <= {1'b0, dnLimit_r} |=>
    dnForward && !dnHeld) else $error("fitting request held");
  up_all_a: assert property (
    upReqValid && upLimit_r == 16'hffff |=> upForward && !upHeld)
    else $error("unlimited not forwarded");
  up_idle_a: assert property (!upReqValid |=> !upForward && !upHeld)
    else $error("upstream result without request");
  dn_idle_a: assert property (!dnReqValid |=> !dnForward && !dnHeld)
    else $error("downstream result without request");
  up_sticky_a: assert property (upDelayed_r && !clrUp |=>
    upDelayed_r) else $error("delayed flag dropped");
  up_clear_a: assert property (clrUp && !upHeldC |=>
    !upDelayed_r) else $error("delayed flag not cleared");
  dn_clear_a: assert property (clrDn && !dnHeldC |=>
    !dnDelayed_r) else $error("delayed flag not cleared");
  up_wins_a: assert property (upHeldC |=> upDelayed_r)
    else $error("new hold lost to clear");
  dn_wins_a: assert property (dnHeldC |=> dnDelayed_r)
    else $error("new hold lost to clear");
  dn_lane_a: assert property (
    wrAcc && selDn && !pstrb[3] |=> dnLimit_r[15:8] == $past(dnLimit_r[15:8]))
    else $error("disabled byte lane written");
  ro_write_a: assert property (wrAcc && !selUp && !selDn |=>
    upLimit_r == $past(upLimit_r) && dnLimit_r == $past(dnLimit_r))
    else $error("read-only write changed a limit");
  err_resp_a: assert property (access && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  ok_resp_a: assert property (access && mapped |=> !pslverr)
    else $error("mapped access refused");
  rd_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  idle_ready_a: assert property (!psel |=> !pready)
    else $error("answer without select");
  stat_rd_a: assert property (access && !pwrite && selStat |=>
    prdata[1:0] == {$past(dnDelayed_r), $past(upDelayed_r)})
    else $error("delayed status read wrong");
  req_rd_a: assert property (access && !pwrite && selReq |=>
    prdata[3:0] == {$past(dnHeld_r), $past(upHeld_r),
                    $past(dnForward_r), $past(upForward_r)})
    else $error("request result read wrong");

  // ****************************************
  // coverage
  // ****************************************
  cov_write_c: cover property (wrAcc && selUp);
  cov_hold_c: cover property (upHeld);
  cov_unlim_c: cover property (dnForward && dnLimit_r == 16'hffff);
  cov_err_c: cover property (pslverr);
  cov_clear_c: cover property (clrUp && upDelayed_r);
endmodule

// >>> verif/sapc_regs_tb.sv
// testbench for the split transaction and power capability registers
`timescale 1ns/1ns
module sapc_regs_tb;
  import sapc_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pstrb, gateSeen, gateNote;
  logic upReqValid, dnReqValid, upForward, dnForward, upHeld, dnHeld;
  logic [15:0] upReqSize, upOutstanding, dnReqSize, dnOutstanding;
  logic [15:0] upLim, dnLim;
  logic [33:0] busQ[$];
  logic [3:0] gateQ[$];
  logic [33:0] busNote;
  logic [1:0] dly;
  logic upF, dnF;
  int miscompares, num_checks, i;
  integer seed = 32'ha1ce8554;
  sapc_regs DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upReqValid(upReqValid), .upReqSize(upReqSize),
    .upOutstanding(upOutstanding), .dnReqValid(dnReqValid),
    .dnReqSize(dnReqSize), .dnOutstanding(dnOutstanding),
    .upForward(upForward), .dnForward(dnForward), .upHeld(upHeld),
    .dnHeld(dnHeld));
  assign gateSeen = {upForward, dnForward, upHeld, dnHeld};
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // notes are {is read, expected pslverr, expected prdata}
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (busQ.size() == 0) begin
        chk("unexpected answer", {31'h0, pready}, 32'h0);
      end else begin
        busNote = busQ.pop_front();
        chk("pslverr", {31'h0, pslverr}, {31'h0, busNote[32]});
        if (busNote[33]) chk("prdata", prdata, busNote[31:0]);
      end
    end
    if (gateSeen !== 4'h0) begin
      if (gateQ.size() == 0) begin
        chk("unexpected gate", {28'h0, gateSeen}, 32'h0);
      end else begin
        gateNote = gateQ.pop_front();
        chk("gate", {28'h0, gateSeen}, {28'h0, gateNote});
      end
    end
  end
  // ****************************************
  // drivers
  // ****************************************
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [3:0] s, logic [33:0] note);
    busQ.push_back(note);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // valids stay up between calls so no signal is set twice in one step
  task automatic req(logic [15:0] us, uo, ds, dOut);
    upF = upLim == 16'hffff || {1'b0, us} + uo <= {1'b0, upLim};
    dnF = dnLim == 16'hffff || {1'b0, ds} + dOut <= {1'b0, dnLim};
    gateQ.push_back({upF, dnF, !upF, !dnF});
    dly = dly | {!dnF, !upF};
    upReqValid <= 1'b1;
    dnReqValid <= 1'b1;
    upReqSize <= us;
    upOutstanding <= uo;
    dnReqSize <= ds;
    dnOutstanding <= dOut;
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {upReqValid, dnReqValid, upReqSize, upOutstanding} = '0;
    {dnReqSize, dnOutstanding} = '0;
    dly = 2'h0;
    dnLim = 16'h0010;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(0, 8'h88, 0, 4'h0, {2'h2, 32'h0010_0010});
    apb(0, 8'h8c, 0, 4'h0, {2'h2, 32'h0010_0010});
    apb(0, 8'h90, 0, 4'h0, {2'h2, 32'hc842_a801});
    apb(1, 8'h90, 32'hffff_ffff, 4'hf, 34'h0);
    apb(0, 8'h90, 0, 4'h0, {2'h2, 32'hc842_a801});
    apb(0, 8'h80, 0, 4'h0, {2'h3, 32'h0});
    apb(1, 8'h7c, 32'h1234_5678, 4'hf, {2'h1, 32'h0});
    rnd = $random(seed);
    apb(1, 8'h88, rnd, 4'hf, 34'h0);
    apb(0, 8'h88, 0, 4'h0, {2'h2, rnd[31:16], 16'h0010});
    // only lane 2 is enabled, so the upper limit byte keeps its reset value
    apb(1, 8'h8c, 32'h5a3c_ffff, 4'h4, 34'h0);
    apb(0, 8'h8c, 0, 4'h0, {2'h2, 32'h003c_0010});
    dnLim = 16'h003c;
    apb(1, 8'h88, 32'h0010_ffff, 4'hf, 34'h0);
    upLim = 16'h0010;
    req(16'h8, 16'h8, 16'h1e, 16'h1e);
    req(16'h9, 16'h8, 16'h1f, 16'h1e);
    for (i = 0; i < 40; i++) begin
      rnd = $random(seed);
      req({11'h0, rnd[4:0]}, {11'h0, rnd[9:5]}, {10'h0, rnd[15:10]},
          {10'h0, rnd[21:16]});
    end
    upReqValid <= 1'b0;
    dnReqValid <= 1'b0;
    @(posedge clk);
    apb(1, 8'h88, 32'hffff_0000, 4'hf, 34'h0);
    apb(1, 8'h8c, 32'hffff_0000, 4'hc, 34'h0);
    upLim = 16'hffff;
    dnLim = 16'hffff;
    req(16'hffff, 16'hffff, 16'hffff, 16'hffff);
    upReqValid <= 1'b0;
    dnReqValid <= 1'b0;
    @(posedge clk);
    apb(0, 8'ha0, 0, 4'h0, {2'h2, 32'h0});
    apb(0, 8'ha4, 0, 4'h0, {2'h2, 30'h0, dly});
    apb(1, 8'ha4, 32'h3, 4'hf, 34'h0);
    apb(0, 8'ha4, 0, 4'h0, {2'h2, 32'h0});
    // a second reset must bring both limits back to their reset value
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(0, 8'h88, 0, 4'h0, {2'h2, 32'h0010_0010});
    apb(0, 8'h8c, 0, 4'h0, {2'h2, 32'h0010_0010});
    chk("bus queue", busQ.size(), 0);
    chk("gate queue", gateQ.size(), 0);
    end_sim();
  end
endmodule
